//--- bench/sdcr_host.sv
// host controller model: apb master and register word formatting
// assumes: clk is the block clock, rsp comes from the register block
`timescale 1ns/1ps
module sdcr_host (
    // bus
    input  wire logic                    clk,
    input  wire sdcr_pkg::sdcr_apb_rsp_t rsp,
    output sdcr_pkg::sdcr_apb_req_t      req
);
    import sdcr_pkg::*;
    logic [31:0] last_q;
    logic        last_err;
    initial req = '0;
    // ****************************************
    // one transfer, held until pready is sampled
    // ****************************************
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1)
            @(posedge clk);
        last_q = rsp.prdata;
        last_err = rsp.pslverr;
        req <= '0;
    endtask
    task automatic set_rf(input logic dbl, input logic [3:0] r,
                          input logic [7:0] iv, input logic [11:0] fr,
                          input logic [11:0] md);
        if (fr > md) fr = md;
        xfer(1'b1, 8'h04, {12'h000, dbl, r, md, 3'h1});
        xfer(1'b1, 8'h00, {9'h000, iv, fr, 3'h0});
    endtask
    task automatic set_if(input logic dbl, input logic [14:0] r,
                          input logic [11:0] b, input logic [5:0] a,
                          input logic [1:0] p);
        if (a > b) a = b[5:0];
        xfer(1'b1, 8'h14, {13'h0000, dbl, r, 3'h5});
        xfer(1'b1, 8'h10, {9'h000, p, b, a, 3'h4});
    endtask
    task automatic set_ctrl(input logic [2:0] c);
        if (c != 3'h0 && c != 3'h1) c = 3'h7;
        xfer(1'b1, 8'h08, {16'h0000, c[2], 3'h0, c[1], 4'h0, c[0], 6'h02});
    endtask
endmodule // sdcr_host

//--- bench/sdcr_monitor.sv
// checker for the divider config register block
// assumes: bound to the ports of sdcr_regs, one clock domain
`timescale 1ns/1ps
module sdcr_monitor (
    // clock and reset
    input wire logic                    REF_CLK,
    input wire logic                    RESET_N,
    // register bus
    input wire sdcr_pkg::sdcr_apb_req_t APB_REQ,
    input wire sdcr_pkg::sdcr_apb_rsp_t APB_RSP,
    // mode outputs
    input wire logic                    DITHER_EN,
    input wire logic                    CP_LOW_NOISE
);
    import sdcr_pkg::*;
    logic       setup;
    logic       ctl;
    logic [2:0] idx;
    logic [2:0] code;
    assign setup = APB_REQ.psel && !APB_REQ.penable;
    assign ctl = APB_REQ.psel && APB_REQ.penable && APB_RSP.pready
        && APB_REQ.pwrite && !APB_RSP.pslverr && APB_REQ.paddr == 8'h08;
    assign idx = APB_REQ.paddr[4:2];
    assign code = {APB_REQ.pwdata[15], APB_REQ.pwdata[11], APB_REQ.pwdata[6]};
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    // ****************************************
    // bus answers and refusals
    // ****************************************
    AST_READY_NEXT: assert property (setup |=> APB_RSP.pready)
        else $error("pready missing after setup");
    AST_READY_ONE: assert property (APB_RSP.pready |=> !APB_RSP.pready)
        else $error("pready longer than one cycle");
    AST_ERR_READY: assert property (APB_RSP.pslverr |-> APB_RSP.pready)
        else $error("pslverr without pready");
    AST_SEL_BAD: assert property (setup && APB_REQ.pwrite
        && APB_REQ.paddr[7:5] == 3'h0 && idx inside {0, 1, 2, 4, 5}
        && APB_REQ.pwdata[2:0] != idx |=> APB_RSP.pslverr)
        else $error("select mismatch accepted");
    AST_SEL_GOOD: assert property (setup && APB_REQ.pwrite
        && APB_REQ.paddr[7:5] == 3'h0 && idx inside {0, 1, 2, 4, 5}
        && APB_REQ.pwdata[2:0] == idx |=> !APB_RSP.pslverr)
        else $error("matching select refused");
    // ****************************************
    // noise and spur modes
    // ****************************************
    AST_LOW_SPUR: assert property (ctl && code == 3'h0
        |-> ##[1:2] DITHER_EN && !CP_LOW_NOISE)
        else $error("lowest spur mode not set");
    AST_BALANCED: assert property (ctl && code == 3'h1
        |-> ##[1:2] !DITHER_EN && !CP_LOW_NOISE)
        else $error("balanced mode not set");
    AST_LOW_NOISE: assert property (ctl && code == 3'h7
        |-> ##[1:2] CP_LOW_NOISE && !DITHER_EN)
        else $error("lowest noise mode not set");
    AST_MODE_EXCL: assert property (!(DITHER_EN && CP_LOW_NOISE))
        else $error("dither on in lowest noise mode");
endmodule // sdcr_monitor

bind sdcr_regs sdcr_monitor mon (
    .REF_CLK      (REF_CLK),
    .RESET_N      (RESET_N),
    .APB_REQ      (APB_REQ),
    .APB_RSP      (APB_RSP),
    .DITHER_EN    (DITHER_EN),
    .CP_LOW_NOISE (CP_LOW_NOISE)
);

//--- bench/sdcr_regs_tb_top.sv
// testbench for the divider config registers
// assumes: 20 MHz clock, pins toggled by free counters of the bench
`timescale 1ns/1ps
module sdcr_regs_tb_top;
    import sdcr_pkg::*;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic [31:0]   pc = '0;
    logic          ref_in = 1'b0;
    logic          rf_in = 1'b0;
    logic          if_in = 1'b0;
    sdcr_apb_req_t req;
    sdcr_apb_rsp_t rsp;
    logic          rf_ref, rf_fb, if_ref, if_fb, dith, cpln;
    int            n_fail = 0;
    int            comparisons = 0;
    logic [23:0]   lf = 24'h0159bb;
    logic [31:0]   mdl [8];
    int            ixs [5] = '{0, 1, 2, 4, 5};
    always #25 clk = ~clk;
    // reference falls every 16 cycles, feedback pins rise every 4
    always @(posedge clk)
    begin
        pc <= pc + 1;
        ref_in <= pc[3];
        rf_in <= pc[1];
        if_in <= pc[1];
    end
    sdcr_host h (.clk(clk), .rsp(rsp), .req(req));
    sdcr_regs uut (
        .REF_CLK         (clk),
        .RESET_N         (rst_n),
        .APB_REQ         (req),
        .APB_RSP         (rsp),
        .REFERENCE_INPUT (ref_in),
        .RF_INPUT        (rf_in),
        .IF_INPUT        (if_in),
        .RF_PFD_REF      (rf_ref),
        .RF_PFD_FB       (rf_fb),
        .IF_PFD_REF      (if_ref),
        .IF_PFD_FB       (if_fb),
        .DITHER_EN       (dith),
        .CP_LOW_NOISE    (cpln)
    );
    function automatic logic [23:0] nxt(input logic [23:0] x);
        return {x[22:0], x[23] ^ x[22] ^ x[21] ^ x[16]};
    endfunction
    function automatic logic pulse(input int w);
        case (w)
            0: return rf_ref;
            1: return if_ref;
            2: return rf_fb;
            default: return if_fb;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        comparisons++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic wait_p(input int w, inout int c);
        do
        begin
            @(negedge clk);
            c++;
        end
        while (pulse(w) !== 1'b1);
    endtask
    // cycles spanned by k divider periods, after settling two pulses
    task automatic meas(input int w, input int k, input int e);
        int c;
        c = 0;
        repeat (2) wait_p(w, c);
        c = 0;
        repeat (k) wait_p(w, c);
        chk("period", e, c);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #(50 * 30000);
        n_fail++;
        print_verdict;
    end
    initial
    begin
        int          ix;
        logic [31:0] d;
        logic [31:0] mk;
        int          cs [3];
        cs = '{0, 1, 7};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int r = 0; r < 10; r++)
        begin
            ix = ixs[r % 5];
            lf = nxt(lf);
            d = {8'h00, lf};
            d[2:0] = ix[2:0];
            if (ix == 0) d[14:3] = '0;
            if (ix == 2) d[15:11] = '0;
            if (ix == 4) d[8:3] = '0;
            mk = (ix == 2) ? 32'h0000ffff : (ix == 5) ? 32'h0007ffff
                : 32'h00ffffff;
            mdl[ix] = d & mk;
            h.xfer(1'b1, 8'(ix * 4), d);
            chk("wr_err", 0, h.last_err);
            h.xfer(1'b0, 8'(ix * 4), 0);
            chk("rd_data", mdl[ix], h.last_q);
        end
        h.xfer(1'b1, 8'h00, 32'h00000001);
        chk("sel_err", 1, h.last_err);
        h.xfer(1'b1, 8'h20, 32'h00000001);
        chk("unmapped_err", 1, h.last_err);
        h.xfer(1'b1, 8'h1c, 32'h00000007);
        chk("status_err", 1, h.last_err);
        h.xfer(1'b0, 8'h0c, 0);
        chk("idx3_err", 1, h.last_err);
        h.xfer(1'b0, 8'h00, 0);
        chk("kept", mdl[0], h.last_q);
        foreach (cs[i])
        begin
            h.set_ctrl(3'(cs[i]));
            repeat (3) @(negedge clk);
            chk("dither", {31'h0, cs[i] == 0}, {31'h0, dith});
            chk("cp_low", {31'h0, cs[i] == 7}, {31'h0, cpln});
        end
        h.set_rf(1'b0, 4'h1, 8'h05, 12'h000, 12'h007);
        meas(0, 1, 16);
        meas(2, 1, 20);
        h.set_rf(1'b0, 4'hf, 8'h05, 12'h001, 12'h002);
        meas(0, 1, 240);
        meas(2, 2, 44);
        h.set_rf(1'b1, 4'h3, 8'h04, 12'h003, 12'h003);
        meas(0, 1, 24);
        meas(2, 1, 20);
        h.set_if(1'b0, 15'h0002, 12'h003, 6'h02, 2'h0);
        meas(1, 1, 32);
        meas(3, 1, 104);
        h.set_if(1'b1, 15'h0005, 12'h002, 6'h01, 2'h1);
        meas(1, 1, 40);
        meas(3, 1, 132);
        // status: carry set (numerator equals modulus), lowest noise on
        h.xfer(1'b0, 8'h1c, 0);
        chk("status", 32'h00005000, h.last_q & 32'hfffff000);
        // program word dispatches by its select bits
        h.xfer(1'b1, 8'h18, 32'h00000042);
        chk("prog_err", 0, h.last_err);
        h.xfer(1'b0, 8'h08, 0);
        chk("prog_ctrl", 32'h00000042, h.last_q);
        h.xfer(1'b0, 8'h18, 0);
        chk("prog_rd", 0, h.last_q);
        h.xfer(1'b1, 8'h18, 32'h00000003);
        chk("prog_sel_err", 1, h.last_err);
        repeat (3) @(negedge clk);
        chk("bal_dither", 0, {31'h0, dith});
        chk("bal_cp_low", 0, {31'h0, cpln});
        print_verdict;
    end
endmodule // sdcr_regs_tb_top

//--- core/sdcr_pkg.sv
// constants, field layouts and bus carriers for the divider config registers
// assumes: 32-bit apb, one aligned word per register index
package sdcr_pkg;

    // ************************************************************
    // register indices, byte address is four times the index
    // ************************************************************
    localparam logic [2:0] IDX_RF_FB   = 3'h0;
    localparam logic [2:0] IDX_RF_REF  = 3'h1;
    localparam logic [2:0] IDX_RF_CTRL = 3'h2;
    localparam logic [2:0] IDX_IF_N    = 3'h4;
    localparam logic [2:0] IDX_IF_REF  = 3'h5;
    localparam logic [2:0] IDX_PROG    = 3'h6;
    localparam logic [2:0] IDX_STATUS  = 3'h7;
    localparam int         ADDR_W      = 8;
    localparam int         WORD_W      = 24;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int SEL_MSB      = 2;
    localparam int FB_FRACTION_NUMERATOR_LSB  = 3;
    localparam int FRACTION_NUMERATOR_W       = 12;
    localparam int FB_INT_LSB   = 15;
    localparam int INT_W        = 8;
    localparam int RR_MOD_LSB   = 3;
    localparam int RR_CNT_LSB   = 15;
    localparam int RR_CNT_W     = 4;
    localparam int RR_DBL_BIT   = 19;
    localparam int RC_NS_HI     = 15;
    localparam int RC_NS_MID    = 11;
    localparam int RC_NS_LO     = 6;
    localparam int RC_W         = 16;
    localparam int IR_CNT_LSB   = 3;
    localparam int IR_CNT_W     = 15;
    localparam int IR_DBL_BIT   = 18;
    localparam int IR_W         = 19;
    localparam int IN_A_LSB     = 3;
    localparam int IN_A_W       = 6;
    localparam int IN_B_LSB     = 9;
    localparam int IN_B_W       = 12;
    localparam int IN_P_LSB     = 21;
    localparam int IN_N_W       = 19;
    localparam int IN_P_SHIFT   = 3;

    // ************************************************************
    // noise and spur codes
    // ************************************************************
    localparam logic [2:0] NS_LOW_SPUR  = 3'h0;
    localparam logic [2:0] NS_BALANCED  = 3'h1;
    localparam logic [2:0] NS_LOW_NOISE = 3'h7;
    localparam logic [14:0] LFSR_SEED   = 15'h0001;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } sdcr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sdcr_apb_rsp_t;

endpackage

//--- core/sdcr_regs.sv
// configuration registers and reference/feedback dividers of a synthesizer
// assumes: apb master on REF_CLK, pins sampled into REF_CLK domain
// How it works
// R1: if feedback divide equals main count times prescaler plus swallow count
// R2: host keeps main count at least swallow count for contiguous values
// R3: if reference word is 19 bits: doubler, 15-bit count, select 101
// R4: word with select 000 loads the rf feedback register
// R5: 8-bit integer field sets integer part of rf feedback division
// R6: 12-bit fraction field is the interpolator numerator
// R7: host keeps fraction numerator not above the modulus
// R8: word with select 001 loads the rf reference register
// R9: prescaler with integer, fraction and modulus forms rf feedback division; here no prescaler, divides by integer plus carry
// R10: rf doubler bit doubles reference before the 4-bit counter
// R11: doubler off uses falling edges only, on uses both edges
// R12: rf reference counter divides by 1 through 15
// R13: 12-bit modulus field sets the fractional modulus
// R14: word with select 010 loads the rf_control
// R15: host writes control bits 15 to 11 as zero at start
// R16: noise code 000 selects lowest spur with dither on
// R17: noise code 001 selects balanced mode with dither off
// R18: noise code 111 selects lowest noise, dither off, charge pump optimum
// R19: word with select 101 loads the if reference register
// R20: if reference counter divides by 1 through 32767
// R21: a register changes only when a whole word is taken
// R22: host writes no other noise codes
`timescale 1ns/1ps

// ****************************************************************
// divide-by-ratio counter on an input tick
// ****************************************************************
module sdcr_div #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         tick,
    input  wire logic [W-1:0] ratio,
    output logic              pulse
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         pulse_q;
    logic         pulse_d;

    always_comb
    begin
        cnt_d   = cnt_q;
        pulse_d = 1'b0;
        if (tick)
        begin
            // ratio 0 behaves as 1
            pulse_d = (ratio <= W'(1)) || (cnt_q >= ratio - W'(1));
            cnt_d   = pulse_d ? '0 : cnt_q + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q   <= '0;
            pulse_q <= 1'b0;
        end
        else
        begin
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse = pulse_q;
endmodule // sdcr_div

// ****************************************************************
// top: apb slave, registers and dividers
// ****************************************************************
module sdcr_regs (
    // clock and reset
    input  wire logic                   REF_CLK,
    input  wire logic                   RESET_N,
    // register bus
    input  wire sdcr_pkg::sdcr_apb_req_t APB_REQ,
    output sdcr_pkg::sdcr_apb_rsp_t      APB_RSP,
    // pins
    input  wire logic                   REFERENCE_INPUT,
    input  wire logic                   RF_INPUT,
    input  wire logic                   IF_INPUT,
    // detector clocks
    output logic                        RF_PFD_REF,
    output logic                        RF_PFD_FB,
    output logic                        IF_PFD_REF,
    output logic                        IF_PFD_FB,
    // mode outputs
    output logic                        DITHER_EN,
    output logic                        CP_LOW_NOISE
);
    import sdcr_pkg::*;

    // ************************************************************
    // pin synchronisers and edge detect
    // ************************************************************
    logic [2:0] ref_q;
    logic [2:0] rfin_q;
    logic [2:0] ifin_q;

    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ref_q  <= '0;
            rfin_q <= '0;
            ifin_q <= '0;
        end
        else
        begin
            ref_q  <= {ref_q[1:0], REFERENCE_INPUT};
            rfin_q <= {rfin_q[1:0], RF_INPUT};
            ifin_q <= {ifin_q[1:0], IF_INPUT};
        end
    end

    logic ref_rise;
    logic ref_fall;
    logic rf_in_tick;
    logic if_in_tick;
    assign ref_rise   = ref_q[1] & ~ref_q[2];
    assign ref_fall   = ~ref_q[1] & ref_q[2];
    assign rf_in_tick = rfin_q[1] & ~rfin_q[2];
    assign if_in_tick = ifin_q[1] & ~ifin_q[2];

    // ************************************************************
    // apb slave and register file
    // ************************************************************
    logic [WORD_W-1:0] rf_fb_q,   rf_fb_d;
    logic [WORD_W-1:0] rf_ref_q,  rf_ref_d;
    logic [RC_W-1:0]   rf_ctrl_q, rf_ctrl_d;
    logic [WORD_W-1:0] if_n_q,    if_n_d;
    logic [IR_W-1:0]   if_ref_q,  if_ref_d;
    sdcr_apb_rsp_t     rsp_q,     rsp_d;
    logic [31:0]       status;

    // returns {accepted, target index}
    function automatic logic [3:0] decode(input sdcr_apb_req_t r);
        logic [2:0] idx;
        logic [2:0] sel;
        logic       ok;
        idx = r.paddr[4:2];
        // the program word dispatches a write by its own select bits
        sel = (r.pwrite && idx == IDX_PROG) ? r.pwdata[SEL_MSB:0] : idx;
        ok  = (r.paddr[ADDR_W-1:5] == '0) && (sel != 3'h3);
        if (r.pwrite)
            ok = ok && (sel < IDX_PROG) && (r.pwdata[SEL_MSB:0] == sel);
        return {ok, sel};
    endfunction

    logic [3:0] dec;
    logic       acc_ph;
    assign dec    = decode(APB_REQ);
    assign acc_ph = APB_REQ.psel & APB_REQ.penable & rsp_q.pready;

    always_comb
    begin
        rf_fb_d   = rf_fb_q;
        rf_ref_d  = rf_ref_q;
        rf_ctrl_d = rf_ctrl_q;
        if_n_d    = if_n_q;
        if_ref_d  = if_ref_q;
        rsp_d     = '0;
        if (APB_REQ.psel && !APB_REQ.penable)
        begin
            rsp_d.pready  = 1'b1;
            rsp_d.pslverr = ~dec[3];
            if (dec[3] && !APB_REQ.pwrite)
            begin
                case (APB_REQ.paddr[4:2])
                    IDX_RF_FB:   rsp_d.prdata = 32'(rf_fb_q);
                    IDX_RF_REF:  rsp_d.prdata = 32'(rf_ref_q);
                    IDX_RF_CTRL: rsp_d.prdata = 32'(rf_ctrl_q);
                    IDX_IF_N:    rsp_d.prdata = 32'(if_n_q);
                    IDX_IF_REF:  rsp_d.prdata = 32'(if_ref_q);
                    IDX_STATUS:  rsp_d.prdata = status;
                    default:     rsp_d.prdata = '0;
                endcase
            end
        end
        // whole word taken in one edge only
        if (acc_ph && APB_REQ.pwrite && dec[3]) // [R21]
        begin
            case (dec[2:0])
                IDX_RF_FB:   rf_fb_d   = APB_REQ.pwdata[WORD_W-1:0]; // [R4]
                IDX_RF_REF:  rf_ref_d  = APB_REQ.pwdata[WORD_W-1:0]; // [R8]
                IDX_RF_CTRL: rf_ctrl_d = APB_REQ.pwdata[RC_W-1:0]; // [R14]
                IDX_IF_N:    if_n_d    = APB_REQ.pwdata[WORD_W-1:0];
                IDX_IF_REF:  if_ref_d  = APB_REQ.pwdata[IR_W-1:0]; // [R3] [R19]
                default:     rf_fb_d   = rf_fb_q;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rf_fb_q   <= '0;
            rf_ref_q  <= '0;
            rf_ctrl_q <= '0;
            if_n_q    <= '0;
            if_ref_q  <= '0;
            rsp_q     <= '0;
        end
        else
        begin
            rf_fb_q   <= rf_fb_d;
            rf_ref_q  <= rf_ref_d;
            rf_ctrl_q <= rf_ctrl_d;
            if_n_q    <= if_n_d;
            if_ref_q  <= if_ref_d;
            rsp_q     <= rsp_d;
        end
    end

    assign APB_RSP = rsp_q;

    // ************************************************************
    // field extraction
    // ************************************************************
    logic [INT_W-1:0]    int_val;
    logic [FRACTION_NUMERATOR_W-1:0]   fraction_numerator_val;
    logic [FRACTION_NUMERATOR_W-1:0]   mod_val;
    logic [RR_CNT_W-1:0] rf_r_val;
    logic [IR_CNT_W-1:0] if_r_val;
    logic [2:0]          ns_code;
    logic [IN_N_W-1:0]   if_n_val;

    assign int_val  = rf_fb_q[FB_INT_LSB +: INT_W]; // [R5]
    assign fraction_numerator_val = rf_fb_q[FB_FRACTION_NUMERATOR_LSB +: FRACTION_NUMERATOR_W]; // [R6]
    assign mod_val  = rf_ref_q[RR_MOD_LSB +: FRACTION_NUMERATOR_W]; // [R13]
    assign rf_r_val = rf_ref_q[RR_CNT_LSB +: RR_CNT_W];
    assign if_r_val = if_ref_q[IR_CNT_LSB +: IR_CNT_W];
    assign ns_code  = {rf_ctrl_q[RC_NS_HI], rf_ctrl_q[RC_NS_MID],
                       rf_ctrl_q[RC_NS_LO]};
    // main count times prescaler modulus plus swallow count
    assign if_n_val = (IN_N_W'(if_n_q[IN_B_LSB +: IN_B_W])
                       << (IN_P_SHIFT + 32'(if_n_q[IN_P_LSB +: 2])))
                      + IN_N_W'(if_n_q[IN_A_LSB +: IN_A_W]); // [R1]

    // ************************************************************
    // reference dividers and if feedback divider
    // ************************************************************
    logic rf_ref_tick;
    logic if_ref_tick;
    // doubler off: falling edge only, on: both edges
    assign rf_ref_tick = rf_ref_q[RR_DBL_BIT] ? (ref_rise | ref_fall)
                                              : ref_fall; // [R10] [R11]
    assign if_ref_tick = if_ref_q[IR_DBL_BIT] ? (ref_rise | ref_fall)
                                              : ref_fall;

    sdcr_div #(.W(RR_CNT_W)) u_rf_ref (
        .clk   (REF_CLK),
        .rst_n (RESET_N),
        .tick  (rf_ref_tick),
        .ratio (rf_r_val), // [R12]
        .pulse (RF_PFD_REF)
    );

    sdcr_div #(.W(IR_CNT_W)) u_if_ref (
        .clk   (REF_CLK),
        .rst_n (RESET_N),
        .tick  (if_ref_tick),
        .ratio (if_r_val), // [R20]
        .pulse (IF_PFD_REF)
    );

    sdcr_div #(.W(IN_N_W)) u_if_fb (
        .clk   (REF_CLK),
        .rst_n (RESET_N),
        .tick  (if_in_tick),
        .ratio (if_n_val),
        .pulse (IF_PFD_FB)
    );

    // ************************************************************
    // rf fractional feedback divider
    // ************************************************************
    logic [INT_W:0]    fcnt_q,  fcnt_d;
    logic [FRACTION_NUMERATOR_W-1:0] facc_q,  facc_d;
    logic              carry_q, carry_d;
    logic              fbp_q,   fbp_d;
    logic [14:0]       lfsr_q,  lfsr_d;
    logic              dith_q,  dith_d;
    logic              lown_q,  lown_d;
    logic [FRACTION_NUMERATOR_W:0]   sum;
    logic [INT_W:0]    n_now;

    assign n_now = {1'b0, int_val} + (INT_W+1)'(carry_q);

    always_comb
    begin
        fcnt_d  = fcnt_q;
        facc_d  = facc_q;
        carry_d = carry_q;
        fbp_d   = 1'b0;
        lfsr_d  = lfsr_q;
        // dither nudges the numerator lsb with pseudo-random bits
        sum     = {1'b0, facc_q} + {1'b0, fraction_numerator_val ^
                  FRACTION_NUMERATOR_W'(dith_q & lfsr_q[0])};
        dith_d  = (ns_code == NS_LOW_SPUR); // [R16] [R17]
        lown_d  = (ns_code == NS_LOW_NOISE); // [R18]
        if (rf_in_tick)
        begin
            fbp_d  = (n_now <= (INT_W+1)'(1))
                     || (fcnt_q >= n_now - (INT_W+1)'(1)); // [R9]
            fcnt_d = fbp_d ? '0 : fcnt_q + (INT_W+1)'(1);
        end
        // cycle end: pick next divide value (integer plus carry) from interpolator carry
        if (fbp_d)
        begin
            lfsr_d  = {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
            carry_d = (mod_val != '0) && (sum >= {1'b0, mod_val});
            facc_d  = carry_d ? FRACTION_NUMERATOR_W'(sum - {1'b0, mod_val})
                              : FRACTION_NUMERATOR_W'(sum);
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            fcnt_q  <= '0;
            facc_q  <= '0;
            carry_q <= 1'b0;
            fbp_q   <= 1'b0;
            lfsr_q  <= LFSR_SEED;
            dith_q  <= 1'b0;
            lown_q  <= 1'b0;
        end
        else
        begin
            fcnt_q  <= fcnt_d;
            facc_q  <= facc_d;
            carry_q <= carry_d;
            fbp_q   <= fbp_d;
            lfsr_q  <= lfsr_d;
            dith_q  <= dith_d;
            lown_q  <= lown_d;
        end
    end

    assign RF_PFD_FB    = fbp_q;
    assign DITHER_EN    = dith_q;
    assign CP_LOW_NOISE = lown_q;

    // status: accumulator, carry, modes, numerator above modulus
    assign status = {16'h0000, fraction_numerator_val > mod_val, lown_q, dith_q,
                     carry_q, facc_q};
endmodule // sdcr_regs
